/* File: rx_ctl_out.sv */
// Receive control pin drivers: data valid, receive error and collision
// Operation
// (R1) Pins float as straps in reset, drive after
// (R2) MII/GMII: data valid on rising edge
// (R3) MII/GMII: receive error on rising edge
// (R4) RGMII: RX_CTL on both clock edges
// (R5) Two-clock TBI when rate select or strap
// (R6) Normal TBI: bits 8/9, two phase-opposed clocks
// (R7) One-clock TBI: bits 8/9 every rising edge
// (R8) RTBI: bit 4 rising, bit 9 falling
// (R9) RGMII/RTBI: receive error pin floats
// (R10) Collision high during collision, else low
// (R11) Collision path has no clock
// (R12) Loopback without test: collision held low
// (R13) Loopback with test: collision follows test
// (R14) TBI/RTBI: collision pin floats
// (R15) Normal TBI: receive clock times odd groups
// (R16) Normal TBI: even clock output enabled
// (R17) Receiver samples on the launching edges
`timescale 1ns/1ns
`include "rx_ctl_params.svh"
module rx_ctl_out
    import rx_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic rx_clk,
    input wire par_mode_t mode,
    input wire logic tbi_clock_rate_select,
    input wire logic digital_loopback_enable,
    input wire logic collision_test_enable,
    input wire logic collision_test_level,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic word_valid,
    output logic word_ready,
    input wire rx_word_t word_data,
    input wire logic link_pause,
    input wire logic dv_pin_in,
    output logic dv_rise_out,
    output logic dv_fall_out,
    output logic dv_oe_n,
    output logic er_rise_out,
    output logic er_fall_out,
    output logic er_oe_n,
    output logic col_out,
    output logic col_oe_n,
    output logic even_group_rx_clock_en,
    output logic strap_dv
);
    rx_word_if wbus (); // Core to buffer carrier
    logic dv_s1, dv_s2, dv_s3; // Strap pin synchroniser
    logic dv_strap_reg; // Strap level caught in reset
    logic [5:0] cfg_clk; // Mode bits packed for crossing
    logic [5:0] cfg_s1, cfg_s2, cfg_s3; // Config into link domain
    logic [5:0] cfg_link_reg; // Settled config in link domain
    logic rst_s1, rst_s2, rst_s3; // Reset into link domain
    logic link_reset_reg; // Settled link reset
    link_state_t lstate_reg, lstate_next; // Launcher state
    rx_word_t cur; // Word to launch this cycle
    logic dv_r_next, dv_f_next, er_r_next, er_f_next;
    logic dv_fpend_reg, er_fpend_reg; // Falling phase values waiting
    logic col_gate_loop_reg, col_gate_test_reg; // Collision steering
    logic col_float_reg; // Collision pad released
    logic even_clk_reg;
    par_mode_t lmode; // Mode seen by link logic
    logic tbi_two_clk; // Two-clock TBI in link domain

    ////////////////////////////////////////////////////////////////////////
    // Producer side and buffer
    assign wbus.wr_valid = word_valid;
    assign wbus.wr_data = word_data;
    assign word_ready = wbus.wr_ready;
    // A stalled launcher backs the buffer up until word_ready drops
    assign wbus.rd_ready = (lstate_reg == LS_DRIVE) && !link_pause;

    // Gray-pointer buffer carries words from clk into the link clock
    rx_word_buf u_buf (
        .clk(clk),
        .reset(reset),
        .rx_clk(rx_clk),
        .link_reset(link_reset_reg),
        .port(wbus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strap capture: three-stage sync, value frozen at reset release
    always_ff @(posedge clk) begin
        dv_s1 <= dv_pin_in;
        dv_s2 <= dv_s1;
        dv_s3 <= dv_s2;
    end
    // (R1) sample strap in reset
    always_ff @(posedge clk) begin
        if (reset && (dv_s2 == dv_s3)) begin
            dv_strap_reg <= dv_s3;
        end
    end
    // Strap is frozen once reset drops; later pin changes are ignored
    assign strap_dv = dv_strap_reg;
    // (R5) two-clock TBI select
    assign cfg_clk = {mode, tbi_clock_rate_select | dv_strap_reg};

    ////////////////////////////////////////////////////////////////////////
    // Collision steering, registered config only; data path is clockless
    always_ff @(posedge clk) begin
        if (reset) begin
            col_gate_loop_reg <= 1'h0;
            col_gate_test_reg <= 1'h0;
            col_float_reg <= `RXO_OE_FLOAT;
        end else begin
            col_gate_loop_reg <= digital_loopback_enable;
            col_gate_test_reg <= collision_test_enable;
            // (R14) float in TBI and RTBI
            col_float_reg <= (mode == MODE_TBI) || (mode == MODE_RTBI);
        end
    end
    assign col_oe_n = col_float_reg;
    // (R11) no clock in the collision path; a pad must not glitch here
    // (R10) (R12) (R13) collision source select
    assign col_out = col_gate_loop_reg ? (col_gate_test_reg & collision_test_level)
                                       : (tx_active & rx_active);

    ////////////////////////////////////////////////////////////////////////
    // Reset and configuration into the link domain
    // The link sees reset about four rx_clk edges late, so reset must be held
    // long enough to cross; the pins keep their last state until it arrives
    always_ff @(posedge rx_clk) begin
        rst_s1 <= reset;
        rst_s2 <= rst_s1;
        rst_s3 <= rst_s2;
        if (rst_s2 == rst_s3) begin
            link_reset_reg <= rst_s3;
        end
    end
    // Config is quasi-static; a change is taken when stages agree
    always_ff @(posedge rx_clk) begin
        cfg_s1 <= cfg_clk;
        cfg_s2 <= cfg_s1;
        cfg_s3 <= cfg_s2;
        if (link_reset_reg) begin
            cfg_link_reg <= {MODE_MII, 1'h0};
        end else if (cfg_s2 == cfg_s3) begin
            cfg_link_reg <= cfg_s3;
        end
    end
    assign lmode = par_mode_t'(cfg_link_reg[5:1]);
    assign tbi_two_clk = cfg_link_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Launcher state: pins float in reset, drive afterwards
    // One LS_FLOAT cycle after link reset launches idle levels; the pads drive from the first edge
    always_comb begin
        lstate_next = lstate_reg;
        case (lstate_reg)
            LS_FLOAT: begin
                lstate_next = LS_DRIVE;
            end
            LS_DRIVE: begin
                lstate_next = LS_DRIVE;
            end
            default: begin
                lstate_next = LS_FLOAT;
            end
        endcase
    end
    // (R1) drive only after reset
    always_ff @(posedge rx_clk) begin
        if (link_reset_reg) begin
            lstate_reg <= LS_FLOAT;
        end else begin
            lstate_reg <= lstate_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-mode pin values; an empty buffer launches idle levels
    always_comb begin
        cur = wbus.rd_valid && wbus.rd_ready ? wbus.rd_data : '0;
        dv_r_next = cur.dv;
        er_r_next = cur.er;
        dv_f_next = cur.dv;
        er_f_next = cur.er;
        case (lmode)
            MODE_RGMII: begin
                // (R4) RX_CTL: valid rising, valid xor error falling
                dv_f_next = cur.dv ^ cur.er;
                er_r_next = `RXO_IDLE;
                er_f_next = `RXO_IDLE;
            end
            MODE_TBI: begin
                // (R7) one-clock TBI repeats on both phases
                dv_r_next = cur.grp_odd[`RXO_TBI_DV_BIT];
                er_r_next = cur.grp_odd[`RXO_TBI_ER_BIT];
                dv_f_next = dv_r_next;
                er_f_next = er_r_next;
                if (tbi_two_clk) begin
                    // (R6) (R15) odd group rising, even group on inverted clock
                    dv_f_next = cur.grp_even[`RXO_TBI_DV_BIT];
                    er_f_next = cur.grp_even[`RXO_TBI_ER_BIT];
                end
            end
            MODE_RTBI: begin
                // (R8) bit 4 rising, bit 9 falling
                dv_r_next = cur.grp_odd[`RXO_RTBI_RISE_BIT];
                dv_f_next = cur.grp_odd[`RXO_RTBI_FALL_BIT];
                er_r_next = `RXO_IDLE;
                er_f_next = `RXO_IDLE;
            end
            default: begin
                // (R2) (R3) MII and GMII keep frame flags on rising edge
                dv_r_next = cur.dv;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Rising phase launch and enables
    always_ff @(posedge rx_clk) begin
        if (lstate_next != LS_DRIVE || link_reset_reg) begin
            dv_rise_out <= `RXO_IDLE;
            er_rise_out <= `RXO_IDLE;
            dv_fpend_reg <= `RXO_IDLE;
            er_fpend_reg <= `RXO_IDLE;
            dv_oe_n <= `RXO_OE_FLOAT;
            er_oe_n <= `RXO_OE_FLOAT;
            even_clk_reg <= 1'h0;
        end else begin
            dv_rise_out <= dv_r_next;
            er_rise_out <= er_r_next;
            dv_fpend_reg <= dv_f_next;
            er_fpend_reg <= er_f_next;
            dv_oe_n <= `RXO_OE_DRIVE;
            // (R9) error pin floats in RGMII and RTBI
            er_oe_n <= (lmode == MODE_RGMII) || (lmode == MODE_RTBI);
            // (R16) even group clock out in two-clock TBI
            even_clk_reg <= (lmode == MODE_TBI) && tbi_two_clk;
        end
    end
    assign even_group_rx_clock_en = even_clk_reg;
    // Falling phase launch, half a period after the rising one
    // (R17) the receiver must sample both phases in DDR modes
    always_ff @(negedge rx_clk) begin
        dv_fall_out <= dv_fpend_reg;
        er_fall_out <= er_fpend_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // past_ok keeps $past checks off the first edges after link reset
    logic past_ok;
    always_ff @(posedge rx_clk) begin
        past_ok <= !link_reset_reg;
    end
    AST_FLOAT_IN_RESET: assert property (@(posedge rx_clk) // R1
        link_reset_reg |=> dv_oe_n && er_oe_n)
        else $error("control pins driven during reset");
    AST_DRIVE_AFTER: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R1
        past_ok && $past(past_ok) |-> !dv_oe_n)
        else $error("data valid pin not driven after reset");
    AST_GMII_DV: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R2
        ((lmode == MODE_MII) || (lmode == MODE_GMII)) && past_ok && (lstate_reg == LS_DRIVE)
        |=> dv_rise_out == $past(cur.dv))
        else $error("gmii data valid not launched");
    AST_GMII_ER: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R3
        ((lmode == MODE_MII) || (lmode == MODE_GMII)) && past_ok && (lstate_reg == LS_DRIVE)
        |=> er_rise_out == $past(cur.er))
        else $error("mii receive error not launched");
    AST_RGMII_CTL: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R4
        (lmode == MODE_RGMII) && (lstate_reg == LS_DRIVE)
        |=> dv_fpend_reg == ($past(cur.dv) ^ $past(cur.er)))
        else $error("rgmii falling value wrong");
    AST_TBI_EVEN: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R6
        (lmode == MODE_TBI) && tbi_two_clk && (lstate_reg == LS_DRIVE)
        |=> dv_fpend_reg == $past(cur.grp_even[8]) && er_fpend_reg == $past(cur.grp_even[9]))
        else $error("two-clock tbi even group wrong");
    AST_TBI_ONE: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R7
        (lmode == MODE_TBI) && !tbi_two_clk && (lstate_reg == LS_DRIVE)
        |=> dv_rise_out == $past(cur.grp_odd[8]) && er_rise_out == $past(cur.grp_odd[9])
        && dv_fpend_reg == dv_rise_out && er_fpend_reg == er_rise_out)
        else $error("one-clock tbi launch wrong");
    AST_RTBI_BITS: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R8
        (lmode == MODE_RTBI) && (lstate_reg == LS_DRIVE)
        |=> dv_rise_out == $past(cur.grp_odd[4]) && dv_fpend_reg == $past(cur.grp_odd[9]))
        else $error("rtbi bit placement wrong");
    AST_ER_FLOAT: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R9
        (lstate_reg == LS_DRIVE) && ((lmode == MODE_RGMII) || (lmode == MODE_RTBI))
        |=> er_oe_n)
        else $error("error pin driven in ddr mode");
    AST_COL_LOOP: assert property (@(posedge clk) disable iff (reset) // R12
        col_gate_loop_reg && !col_gate_test_reg |-> !col_out)
        else $error("collision not held low in loopback");
    AST_COL_REAL: assert property (@(posedge clk) disable iff (reset) // R10
        !col_gate_loop_reg |-> col_out == (tx_active && rx_active))
        else $error("collision does not follow activity");
    AST_COL_FLOAT: assert property (@(posedge clk) disable iff (reset) // R14
        (mode == MODE_TBI) ##1 (mode == MODE_TBI) |-> col_oe_n)
        else $error("collision driven in tbi");
    AST_EVEN_CLK: assert property (@(posedge rx_clk) disable iff (link_reset_reg) // R16
        (lstate_reg == LS_DRIVE)
        |=> even_group_rx_clock_en == $past((lmode == MODE_TBI) && tbi_two_clk))
        else $error("even group clock enable wrong");
    // Cover points: data through, back-pressure, two-clock TBI, collision
    COV_WORD_OUT: cover property (@(posedge rx_clk) wbus.rd_valid && wbus.rd_ready);
    COV_FULL: cover property (@(posedge clk) word_valid && !word_ready);
    COV_TBI_TWO: cover property (@(posedge rx_clk) (lmode == MODE_TBI) && tbi_two_clk);
    COV_COL: cover property (@(posedge clk) col_out && !col_oe_n);
endmodule // rx_ctl_out

/* File: rx_ctl_out_tb_top.sv */
// Self-checking bench for the receive control pin drivers
`timescale 1ns/1ns
module rx_ctl_out_tb_top;
    import rx_ctl_pkg::*;
    // One row: mode settings, word, expected record and pin enables
    typedef struct {
        par_mode_t mode;
        logic rate;
        rx_word_t word;
        logic [3:0] rec;
        logic [3:0] mask;
        logic [2:0] oes; // er_oe_n, col_oe_n, even clock enable
    } row_t;
    logic clk = 1'h0;
    logic rx_clk = 1'h0;
    logic reset = 1'h1;
    par_mode_t mode = MODE_MII;
    logic tbi_clock_rate_select = 1'h0;
    logic digital_loopback_enable = 1'h0;
    logic collision_test_enable = 1'h0;
    logic collision_test_level = 1'h0;
    logic tx_active = 1'h0;
    logic rx_active = 1'h0;
    logic word_valid = 1'h0;
    rx_word_t word_data = 22'h0;
    logic dv_pin_in = 1'h0;
    logic stall = 1'h0; // Asks the model to pause the link
    logic word_ready, link_pause, dv_rise_out, dv_fall_out, dv_oe_n, er_rise_out;
    logic er_fall_out, er_oe_n, col_out, col_oe_n, even_group_rx_clock_en, strap_dv;
    int fails = 0;
    int check_count = 0;
    int sent;
    row_t rows[$];
    ////////////////////////////////////////////////////////////////
    // Clocks; the link clock is offset so the phases are unrelated
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #7;
        forever #15 rx_clk = ~rx_clk;
    end
    rx_ctl_out dut (.clk, .reset, .rx_clk, .mode, .tbi_clock_rate_select,
        .digital_loopback_enable, .collision_test_enable, .collision_test_level,
        .tx_active, .rx_active, .word_valid, .word_ready, .word_data, .link_pause,
        .dv_pin_in, .dv_rise_out, .dv_fall_out, .dv_oe_n, .er_rise_out, .er_fall_out,
        .er_oe_n, .col_out, .col_oe_n, .even_group_rx_clock_en, .strap_dv);
    rx_mac_model mac (.rx_clk, .stall, .dv_rise_out, .dv_fall_out, .er_rise_out,
        .er_fall_out, .dv_oe_n, .link_pause);
    ////////////////////////////////////////////////////////////////
    task automatic check_bit(input string name, input logic exp, input logic seen);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Masked bits belong to a floating pin and are not compared
    task automatic check_rec(input string name, input logic [3:0] exp,
        input logic [3:0] mask, input logic [3:0] seen);
        check_count++;
        if ((seen & mask) !== (exp & mask)) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp & mask, seen & mask);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic timed_out(input string what);
        fails++;
        $display("[FAIL] %s expected completion seen timeout", what);
        finish_test();
    endtask
    // Offer a word from a falling edge and hold it until taken
    task automatic send_word(input rx_word_t w);
        int n;
        n = 0;
        word_data = w;
        word_valid = 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (word_ready !== 1'h1 && n < 100);
        if (word_ready !== 1'h1) begin
            timed_out("word accept");
        end
        @(negedge clk);
    endtask
    // Wait a bounded time for the model's next record and compare it
    task automatic collect(input string name, input logic [3:0] exp, input logic [3:0] mask);
        int n;
        n = 0;
        while (mac.recs.size() == 0) begin
            if (n == 60) begin
                timed_out(name);
            end
            n++;
            @(negedge clk);
        end
        check_rec(name, exp, mask, mac.recs.pop_front());
    endtask
    function automatic rx_word_t mk(input int i);
        return {1'h1, i[0], 10'h110, 10'h000};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        // Reset is held longer than three cycles so it reaches the link side
        repeat (10) @(negedge clk);
        check_bit("dv_oe_n in reset", 1'h1, dv_oe_n);
        check_bit("er_oe_n in reset", 1'h1, er_oe_n);
        check_bit("col_oe_n in reset", 1'h1, col_oe_n);
        reset = 1'h0;
        repeat (10) @(negedge clk);
        check_bit("dv_oe_n driven", 1'h0, dv_oe_n);
        check_bit("strap_dv low", 1'h0, strap_dv);
        $display("Test reset done");
        // Every mode; TBI and RTBI rows use odd bits so a wrong pick shows
        rows.push_back('{MODE_MII, 1'h0, {2'h2, 10'h110, 10'h000}, 4'hA, 4'hF, 3'h0});
        rows.push_back('{MODE_GMII, 1'h0, {2'h3, 10'h110, 10'h000}, 4'hF, 4'hF, 3'h0});
        rows.push_back('{MODE_RGMII, 1'h0, {2'h2, 10'h110, 10'h000}, 4'hA, 4'hA, 3'h4});
        rows.push_back('{MODE_RGMII, 1'h0, {2'h3, 10'h110, 10'h000}, 4'h8, 4'hA, 3'h4});
        rows.push_back('{MODE_TBI, 1'h0, {2'h0, 10'h310, 10'h000}, 4'hF, 4'hF, 3'h2});
        rows.push_back('{MODE_TBI, 1'h1, {2'h0, 10'h110, 10'h200}, 4'h9, 4'hF, 3'h3});
        rows.push_back('{MODE_RTBI, 1'h0, {2'h0, 10'h210, 10'h000}, 4'hA, 4'hA, 3'h6});
        rows.push_back('{MODE_RTBI, 1'h0, {2'h0, 10'h110, 10'h000}, 4'h8, 4'hA, 3'h6});
        foreach (rows[i]) begin
            mode = rows[i].mode;
            tbi_clock_rate_select = rows[i].rate;
            repeat (4) @(negedge clk);
            check_bit("er_oe_n", rows[i].oes[2], er_oe_n);
            check_bit("col_oe_n", rows[i].oes[1], col_oe_n);
            check_bit("even clock enable", rows[i].oes[0], even_group_rx_clock_en);
            send_word(rows[i].word);
            word_valid = 1'h0;
            collect("pin record", rows[i].rec, rows[i].mask);
        end
        $display("Test mode table done");
        // Stalled receiver: fill until refused, then drain with nothing lost
        mode = MODE_MII;
        tbi_clock_rate_select = 1'h0;
        stall = 1'h1;
        repeat (4) @(negedge clk);
        sent = 0;
        word_valid = 1'h1;
        for (int k = 0; k < 8; k++) begin
            word_data = mk(sent);
            @(posedge clk);
            sent += (word_ready === 1'h1) ? 1 : 0;
            @(negedge clk);
        end
        check_bit("buffer full refuses", 1'h0, word_ready);
        stall = 1'h0;
        send_word(mk(sent));
        word_valid = 1'h0;
        sent++;
        for (int i = 0; i < sent; i++) begin
            collect("stalled record", i[0] ? 4'hF : 4'hA, 4'hF);
        end
        repeat (20) @(negedge clk);
        check_bit("no extra record", 1'h0, mac.recs.size() != 0);
        $display("Test stall done");
        // Collision path settles without any clock edge
        for (int k = 0; k < 4; k++) begin
            tx_active = k[0];
            rx_active = k[1];
            #1;
            check_bit("col_out", k[0] & k[1], col_out);
            @(negedge clk);
        end
        digital_loopback_enable = 1'h1;
        repeat (3) @(negedge clk);
        check_bit("col_out loopback", 1'h0, col_out);
        collision_test_enable = 1'h1;
        for (int k = 0; k < 2; k++) begin
            repeat (3) @(negedge clk);
            collision_test_level = k[0];
            #1;
            check_bit("col_out test", k[0], col_out);
        end
        $display("Test collision done");
        // Second reset with the strap high picks two-clock TBI
        @(negedge clk);
        reset = 1'h1;
        dv_pin_in = 1'h1;
        mode = MODE_TBI;
        repeat (10) @(negedge clk);
        check_bit("dv_oe_n in reset", 1'h1, dv_oe_n);
        reset = 1'h0;
        dv_pin_in = 1'h0;
        repeat (10) @(negedge clk);
        check_bit("strap_dv high", 1'h1, strap_dv);
        check_bit("even clock by strap", 1'h1, even_group_rx_clock_en);
        send_word({2'h0, 10'h110, 10'h200});
        word_valid = 1'h0;
        collect("strap record", 4'h9, 4'hF);
        $display("Test strap done");
        finish_test();
    end
endmodule // rx_ctl_out_tb_top

/* File: rx_ctl_params.svh */
// Constants for the receive control output block
`ifndef RX_CTL_PARAMS_SVH
`define RX_CTL_PARAMS_SVH
// Code group width and bit positions carried on the control pins
`define RXO_GRP_W 10
`define RXO_TBI_DV_BIT 8
`define RXO_TBI_ER_BIT 9
`define RXO_RTBI_RISE_BIT 4
`define RXO_RTBI_FALL_BIT 9
// Buffer depth and pointer width (one address bit plus wrap bit)
`define RXO_BUF_DEPTH 2
`define RXO_PTR_W 2
// Idle level of a control pin
`define RXO_IDLE 1'h0
// Pad output enable levels (active low enable)
`define RXO_OE_DRIVE 1'h0
`define RXO_OE_FLOAT 1'h1
`endif

/* File: rx_ctl_pkg.sv */
// Types shared by the receive control output block
package rx_ctl_pkg;
    // Parallel interface mode, one-hot
    typedef enum logic [4:0] {
        MODE_MII = 5'h01,
        MODE_GMII = 5'h02,
        MODE_RGMII = 5'h04,
        MODE_TBI = 5'h08,
        MODE_RTBI = 5'h10
    } par_mode_t;
    // Link side launcher state, one-hot
    typedef enum logic [1:0] {
        LS_FLOAT = 2'h1,
        LS_DRIVE = 2'h2
    } link_state_t;
    // One buffered word: frame flags and two code groups
    typedef struct packed {
        logic dv;
        logic er;
        logic [9:0] grp_odd;
        logic [9:0] grp_even;
    } rx_word_t;
endpackage

/* File: rx_mac_model.sv */
// Receiving MAC model: samples the control pins on their launching edges
`timescale 1ns/1ns
module rx_mac_model (
    input wire logic rx_clk,
    input wire logic stall,
    input wire logic dv_rise_out,
    input wire logic dv_fall_out,
    input wire logic er_rise_out,
    input wire logic er_fall_out,
    input wire logic dv_oe_n,
    output logic link_pause
);
    logic pend_reg = 1'h0; // Rising phase carried data valid
    logic [1:0] rise_reg = 2'h0; // Rising phase dv, er
    logic [3:0] recs[$]; // Records: rise dv, rise er, fall dv, fall er
    ////////////////////////////////////////////////////////////////
    // Stalls reach the link on its own edge, so a slow receiver is modelled
    always @(posedge rx_clk) begin
        link_pause <= stall;
    end
    always @(posedge rx_clk) begin
        // A released pin carries nothing, so only a driven pin opens a record
        pend_reg <= !dv_oe_n && dv_rise_out;
        rise_reg <= {dv_rise_out, er_rise_out};
    end
    always @(negedge rx_clk) begin
        if (pend_reg) begin
            recs.push_back({rise_reg, dv_fall_out, er_fall_out});
        end
    end
endmodule // rx_mac_model

/* File: rx_word_buf.sv */
// Two-entry dual-clock buffer with gray pointers
`timescale 1ns/1ns
`include "rx_ctl_params.svh"
module rx_word_buf
    import rx_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic rx_clk,
    input wire logic link_reset,
    rx_word_if.store port
);
    // Storage, written in clk domain and read in link domain
    rx_word_t mem [`RXO_BUF_DEPTH];
    logic [1:0] wbin_reg, wbin_next, wgray_reg, wgray_next;
    logic [1:0] rbin_reg, rbin_next, rgray_reg, rgray_next;
    logic [1:0] rg_s1, rg_s2, rg_s3, rg_sync_reg; // Read pointer into clk
    logic [1:0] wg_s1, wg_s2, wg_s3, wg_sync_reg; // Write pointer into link
    logic full_reg, empty_reg;
    logic do_wr, do_rd;

    assign do_wr = port.wr_valid && !full_reg;
    assign do_rd = port.rd_ready && !empty_reg;
    assign wbin_next = wbin_reg + {1'h0, do_wr};
    assign wgray_next = wbin_next ^ {1'h0, wbin_next[1]};
    assign rbin_next = rbin_reg + {1'h0, do_rd};
    assign rgray_next = rbin_next ^ {1'h0, rbin_next[1]};
    assign port.wr_ready = !full_reg;
    assign port.rd_valid = !empty_reg;
    assign port.rd_data = mem[rbin_reg[0]];

    ////////////////////////////////////////////////////////////////////////
    // Write side
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wbin_reg[0]] <= port.wr_data;
        end
    end
    // Write pointer and full flag; full counts from the synced read side
    always_ff @(posedge clk) begin
        if (reset) begin
            wbin_reg <= 2'h0;
            wgray_reg <= 2'h0;
            full_reg <= 1'h0;
        end else begin
            wbin_reg <= wbin_next;
            wgray_reg <= wgray_next;
            full_reg <= (wgray_next == ~rg_sync_reg);
        end
    end
    // Read pointer crossing: accept only when stages two and three agree
    always_ff @(posedge clk) begin
        rg_s1 <= rgray_reg;
        rg_s2 <= rg_s1;
        rg_s3 <= rg_s2;
        if (reset) begin
            rg_sync_reg <= 2'h0;
        end else if (rg_s2 == rg_s3) begin
            rg_sync_reg <= rg_s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read side pointer and empty flag
    always_ff @(posedge rx_clk) begin
        if (link_reset) begin
            rbin_reg <= 2'h0;
            rgray_reg <= 2'h0;
            empty_reg <= 1'h1;
        end else begin
            rbin_reg <= rbin_next;
            rgray_reg <= rgray_next;
            empty_reg <= (rgray_next == wg_sync_reg);
        end
    end
    // Write pointer crossing into the link domain
    always_ff @(posedge rx_clk) begin
        wg_s1 <= wgray_reg;
        wg_s2 <= wg_s1;
        wg_s3 <= wg_s2;
        if (link_reset) begin
            wg_sync_reg <= 2'h0;
        end else if (wg_s2 == wg_s3) begin
            wg_sync_reg <= wg_s3;
        end
    end
endmodule // rx_word_buf

/* File: rx_word_if.sv */
// Word carrier between the block core and its crossing buffer
`timescale 1ns/1ns
interface rx_word_if;
    import rx_ctl_pkg::*;
    logic wr_valid; // Producer offers a word
    logic wr_ready; // Buffer has room
    rx_word_t wr_data; // Word written
    logic rd_valid; // Buffer holds a word
    logic rd_ready; // Consumer takes it
    rx_word_t rd_data; // Head word
    modport fill (input wr_ready, output wr_valid, output wr_data);
    modport drain (input rd_valid, input rd_data, output rd_ready);
    modport store (input wr_valid, input wr_data, output wr_ready,
                   output rd_valid, output rd_data, input rd_ready);
endinterface
